// [rrsm_pkg.sv]
// Purpose: shared constants for the remote reference and status map
// Assumes: register index times four gives the APB byte address
// Notes:   indices and field positions of the configuration word
package rrsm_pkg;
   // register indices (byte address = index * 4)
   localparam logic [5:0] RRSM_IDX_VOLT_KNOB    = 6'h20;
   localparam logic [5:0] RRSM_IDX_GAIN_KNOB    = 6'h21;
   localparam logic [5:0] RRSM_IDX_FREQ_KNOB    = 6'h22;
   localparam logic [5:0] RRSM_IDX_FIELD_KNOB   = 6'h23;
   localparam logic [5:0] RRSM_IDX_MEAS_VOLT    = 6'h24;
   localparam logic [5:0] RRSM_IDX_MEAS_FREQ    = 6'h25;
   localparam logic [5:0] RRSM_IDX_ALARMS       = 6'h26;
   localparam logic [5:0] RRSM_IDX_EFF_CFG      = 6'h27;
   localparam logic [5:0] RRSM_IDX_CMD_WORD     = 6'h28;
   localparam logic [5:0] RRSM_IDX_EXT_INPUT    = 6'h29;
   localparam logic [5:0] RRSM_IDX_NOM_TARGET   = 6'h2A;
   localparam logic [5:0] RRSM_IDX_WORK_TARGET  = 6'h2B;
   localparam logic [5:0] RRSM_IDX_VOLT_SAMPLE  = 6'h2C;
   localparam logic [5:0] RRSM_IDX_HEAT_EST     = 6'h2D;
   localparam logic [5:0] RRSM_IDX_VOL_REF      = 6'h31;
   localparam logic [5:0] RRSM_IDX_SWING        = 6'h32;
   localparam logic [5:0] RRSM_IDX_POLY_LEVEL   = 6'h33;
   localparam logic [5:0] RRSM_IDX_OFFSET_EST   = 6'h34;
   localparam logic [5:0] RRSM_IDX_CFG_WORD     = 6'h10;
   localparam logic [5:0] RRSM_IDX_STORED_REF   = 6'h11;
   localparam logic [5:0] RRSM_IDX_VAR_LIMIT    = 6'h12;
   // configuration word bit positions
   localparam int RRSM_B_OFFSET_COMP = 2;
   localparam int RRSM_B_JUMPER_EN   = 4;
   localparam int RRSM_B_FORCE_3PH   = 6;
   localparam int RRSM_B_RAM_REMOTE  = 7;
   localparam int RRSM_B_EXT_INPUT   = 12;
   localparam int RRSM_B_60HZ        = 14;
   // reset values
   localparam logic [15:0] RRSM_CFG_RST        = 16'h1F14;
   localparam logic [15:0] RRSM_STORED_REF_RST = 16'h4000;
   localparam logic [15:0] RRSM_VAR_LIMIT_RST  = 16'h1200;
   // external input scale
   localparam logic [15:0] RRSM_EXT_CENTRE     = 16'h4000;
   localparam logic [15:0] RRSM_EXT_FULL       = 16'h7FFF;
   localparam int          RRSM_EXT_SHIFT      = 14;
   // reference source modes
   typedef enum logic [3:0] {
      RRSM_MODE_ANALOG     = 4'b0001,
      RRSM_MODE_ANALOG_SAT = 4'b0010,
      RRSM_MODE_DIG_STORED = 4'b0100,
      RRSM_MODE_DIG_RAM    = 4'b1000
   } rrsm_mode_t;
endpackage

// [rrsm_regmap.sv]
// Purpose: APB register map, reference source selection and active configuration status
// Assumes: status inputs come from logic on the same clock; pins are asynchronous
// Notes:   APB answers in the access phase (one wait-free access after setup)
//
// Behaviour
// - ext input and RAM flag set: clamp reference variation at input limit.
// - saturation on and link lost: variation goes to +limit parameter.
// - ext input off, RAM flag clear: reference is stored parameter.
// - RAM flag clear: volatile reference loaded from and kept equal to stored.
// - ext off, RAM flag clear: host writes to volatile reference ignored.
// - ext off, RAM flag set: volatile reference location drives the reference.
// - index 36 reports measured voltage in tenths of volts, read-only.
// - index 37 reports measured frequency in tenths of hertz, read-only.
// - index 41 reports external input value 0..32767, read-only.
// - index 43 gives working setpoint, distinct from nominal at 42.
// - index 45 gives winding temperature estimate, read-only.
// - offset estimate at index 52 only meaningful in single-phase sensing.
// - status word mirrors config except B2, B6, B14 from real state.
// - status B6 reads 1 whenever three-phase sensing is connected.
// - status B14 reads 1 when 60 Hz jumper closed and B4 set.
// - default status reads 7956, 24340, 8016 or 24400 per sensing and 60 Hz jumper.
// - status B12 shows external input enable, B13 external converter enable.
// - config bits enable when 1; default enables B2, B4, B8..B12.
`timescale 1ns/1ps
module rrsm_regmap
   import rrsm_pkg::*;
#(
   parameter int AW = 8                                 // apb address width
) (
   input  wire logic              clock,               // 40 MHz system clock
   input  wire logic              sys_rst,             // synchronous reset, active high
   input  wire logic              ce,                  // clock enable, freezes state when low
   input  wire logic [AW-1:0]     paddr,               // apb byte address
   input  wire logic              psel,                // apb select
   input  wire logic              penable,             // apb access phase
   input  wire logic              pwrite,              // apb write direction
   input  wire logic [31:0]       pwdata,              // apb write data
   output logic [31:0]            prdata,              // apb read data
   output logic                   pready,              // apb ready
   output logic                   pslverr,             // apb error on unmapped address
   input  wire logic              jumper_60hz_pin,     // 60 Hz jumper closed, async pin
   input  wire logic              three_phase_pin,     // three-phase sensing connected, async
   input  wire logic              ext_link_lost_pin,   // external control connection open
   input  wire logic [15:0]       volt_knob,           // voltage knob position
   input  wire logic [15:0]       gain_knob,           // gain knob position
   input  wire logic [15:0]       freq_knob,           // frequency knob position
   input  wire logic [15:0]       field_current_knob,  // field current knob position
   input  wire logic [15:0]       meas_volt_tenths,    // measured voltage, 0.1 V
   input  wire logic [15:0]       meas_freq_tenths,    // measured frequency, 0.1 Hz
   input  wire logic [15:0]       alarm_flags,         // active alarm word
   input  wire logic [15:0]       ext_input_value,     // external input, 0..32767
   input  wire logic [15:0]       nominal_target,      // nominal setpoint
   input  wire logic [15:0]       working_target,      // setpoint after regulator changes
   input  wire logic [15:0]       volt_sample,         // internal voltage sample
   input  wire logic [15:0]       heat_estimate,       // winding temperature estimate
   input  wire logic [15:0]       swing_amplitude,     // swing_amplitude_internal
   input  wire logic [15:0]       polyphase_level,     // three-phase switch threshold
   input  wire logic [15:0]       offset_estimate,     // channel offset estimate
   output logic [15:0]            ref_base,            // selected base reference
   output logic signed [15:0]     ref_variation,       // external variation, 3277 = 10 %
   output logic [3:0]             ref_mode,            // one-hot reference source
   output logic [15:0]            cfg_word             // configuration word to the regulator
);

   // pin synchronisers
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic       jumper_s;
   logic       three_phase_s;
   logic       link_lost_s;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end else if (ce) begin
         pin_meta_r <= {ext_link_lost_pin, three_phase_pin, jumper_60hz_pin};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign jumper_s      = pin_sync_r[0];
   assign three_phase_s = pin_sync_r[1];
   assign link_lost_s   = pin_sync_r[2];

   // apb decode
   logic [5:0] idx;
   logic       setup_ph;
   logic       wr_take;
   logic       hit;
   logic       pready_r;

   assign idx      = paddr[7:2];
   assign setup_ph = psel & ~penable;
   assign wr_take  = psel & penable & pready_r & pwrite;

   function automatic logic mapped(input logic [5:0] i);
      mapped = (i >= RRSM_IDX_VOLT_KNOB && i <= RRSM_IDX_HEAT_EST)
            || (i >= RRSM_IDX_VOL_REF && i <= RRSM_IDX_OFFSET_EST)
            || (i >= RRSM_IDX_CFG_WORD && i <= RRSM_IDX_VAR_LIMIT);
   endfunction

   assign hit = mapped(idx) & (paddr[1:0] == 2'h0);

   // write strobe for one register index
   function automatic logic wr_hit(input logic       take,
                                   input logic [5:0] at,
                                   input logic [5:0] reg_idx);
      wr_hit = take && (at == reg_idx);
   endfunction

   // software registers
   logic [15:0] cfg_r;
   logic [15:0] stored_ref_r;
   logic [15:0] var_limit_r;
   logic [15:0] vol_ref_r;
   logic        ram_remote;
   logic        ext_en;

   assign ram_remote = cfg_r[RRSM_B_RAM_REMOTE];
   assign ext_en     = cfg_r[RRSM_B_EXT_INPUT];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cfg_r <= RRSM_CFG_RST;
      end else if (ce && wr_hit(wr_take & hit, idx, RRSM_IDX_CFG_WORD)) begin
         cfg_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stored_ref_r <= RRSM_STORED_REF_RST;
      end else if (ce && wr_hit(wr_take & hit, idx, RRSM_IDX_STORED_REF)) begin
         stored_ref_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         var_limit_r <= RRSM_VAR_LIMIT_RST;
      end else if (ce && wr_hit(wr_take & hit, idx, RRSM_IDX_VAR_LIMIT)) begin
         var_limit_r <= pwdata[15:0];
      end
   end

   // volatile reference tracks the stored value while the RAM flag is clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vol_ref_r <= RRSM_STORED_REF_RST;
      end else if (ce) begin
         if (!ram_remote) begin
            vol_ref_r <= stored_ref_r;
         end else if (wr_hit(wr_take & hit, idx, RRSM_IDX_VOL_REF)) begin
            vol_ref_r <= pwdata[15:0];
         end
      end
   end

   // active configuration status word
   logic [15:0] eff_cfg;

   always_comb begin
      eff_cfg = cfg_r;
      eff_cfg[RRSM_B_FORCE_3PH] = cfg_r[RRSM_B_FORCE_3PH] | three_phase_s;
      eff_cfg[RRSM_B_OFFSET_COMP] = cfg_r[RRSM_B_OFFSET_COMP]
                                    & ~eff_cfg[RRSM_B_FORCE_3PH];
      eff_cfg[RRSM_B_60HZ] = cfg_r[RRSM_B_60HZ]
                             | (cfg_r[RRSM_B_JUMPER_EN] & jumper_s);
   end

   // reference source selection
   rrsm_mode_t mode;

   always_comb begin
      case ({ext_en, ram_remote})
         2'b10:   mode = RRSM_MODE_ANALOG;
         2'b11:   mode = RRSM_MODE_ANALOG_SAT;
         2'b00:   mode = RRSM_MODE_DIG_STORED;
         2'b01:   mode = RRSM_MODE_DIG_RAM;
         default: mode = RRSM_MODE_DIG_STORED;
      endcase
   end

   // external variation: full input swing maps to plus or minus the limit
   logic signed [16:0] ext_delta;
   logic signed [33:0] ext_prod;
   logic signed [15:0] ext_scaled;
   logic signed [15:0] lim_pos;
   logic signed [15:0] lim_neg;
   logic               at_high;
   logic               at_low;

   assign ext_delta  = $signed({1'b0, ext_input_value}) - $signed({1'b0, RRSM_EXT_CENTRE});
   assign ext_prod   = ext_delta * $signed({1'b0, var_limit_r});
   assign ext_scaled = ext_prod[RRSM_EXT_SHIFT+15:RRSM_EXT_SHIFT];
   assign lim_pos    = $signed(var_limit_r);
   assign lim_neg    = -$signed(var_limit_r);
   assign at_high    = ext_input_value >= RRSM_EXT_FULL;
   assign at_low     = ext_input_value == 16'h0000;

   logic signed [15:0] var_nxt;
   logic [15:0]        base_nxt;

   always_comb begin
      var_nxt  = 16'sh0000;
      base_nxt = stored_ref_r;
      case (mode)
         RRSM_MODE_ANALOG: begin
            var_nxt = ext_scaled;
         end
         RRSM_MODE_ANALOG_SAT: begin
            if (link_lost_s || at_high) begin
               var_nxt = lim_pos;
            end else if (at_low) begin
               var_nxt = lim_neg;
            end else begin
               var_nxt = ext_scaled;
            end
         end
         RRSM_MODE_DIG_STORED: begin
            base_nxt = stored_ref_r;
         end
         RRSM_MODE_DIG_RAM: begin
            base_nxt = vol_ref_r;
         end
         default: begin
            base_nxt = stored_ref_r;
         end
      endcase
   end

   logic [15:0]        ref_base_r;
   logic signed [15:0] ref_var_r;
   logic [3:0]         ref_mode_r;
   logic [15:0]        cfg_out_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ref_base_r <= RRSM_STORED_REF_RST;
      end else if (ce) begin
         ref_base_r <= base_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ref_var_r <= 16'sh0000;
      end else if (ce) begin
         ref_var_r <= var_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ref_mode_r <= RRSM_MODE_ANALOG;
      end else if (ce) begin
         ref_mode_r <= mode;
      end
   end

   // regulator sees the configuration word one cycle after the bus write
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cfg_out_r <= RRSM_CFG_RST;
      end else if (ce) begin
         cfg_out_r <= cfg_r;
      end
   end

   assign ref_base      = ref_base_r;
   assign ref_variation = ref_var_r;
   assign ref_mode      = ref_mode_r;
   assign cfg_word      = cfg_out_r;

   // read mux; write-only locations read as zero
   logic [15:0] rd_nxt;

   always_comb begin
      case (idx)
         RRSM_IDX_VOLT_KNOB:   rd_nxt = volt_knob;
         RRSM_IDX_GAIN_KNOB:   rd_nxt = gain_knob;
         RRSM_IDX_FREQ_KNOB:   rd_nxt = freq_knob;
         RRSM_IDX_FIELD_KNOB:  rd_nxt = field_current_knob;
         RRSM_IDX_MEAS_VOLT:   rd_nxt = meas_volt_tenths;
         RRSM_IDX_MEAS_FREQ:   rd_nxt = meas_freq_tenths;
         RRSM_IDX_ALARMS:      rd_nxt = alarm_flags;
         RRSM_IDX_EFF_CFG:     rd_nxt = eff_cfg;
         RRSM_IDX_EXT_INPUT:   rd_nxt = ext_input_value;
         RRSM_IDX_NOM_TARGET:  rd_nxt = nominal_target;
         RRSM_IDX_WORK_TARGET: rd_nxt = working_target;
         RRSM_IDX_VOLT_SAMPLE: rd_nxt = volt_sample;
         RRSM_IDX_HEAT_EST:    rd_nxt = heat_estimate;
         RRSM_IDX_SWING:       rd_nxt = swing_amplitude;
         RRSM_IDX_POLY_LEVEL:  rd_nxt = polyphase_level;
         RRSM_IDX_OFFSET_EST:  rd_nxt = eff_cfg[RRSM_B_FORCE_3PH]
                                        ? 16'h0000 : offset_estimate;
         RRSM_IDX_CFG_WORD:    rd_nxt = cfg_r;
         RRSM_IDX_STORED_REF:  rd_nxt = stored_ref_r;
         RRSM_IDX_VAR_LIMIT:   rd_nxt = var_limit_r;
         default:              rd_nxt = 16'h0000;
      endcase
   end

   // apb answer: ready and data are set up during the setup cycle
   logic [31:0] prdata_r;
   logic        pslverr_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pready_r <= 1'b0;
      end else if (ce) begin
         pready_r <= setup_ph;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (ce && setup_ph) begin
         // writes to read-only or reserved words complete without effect
         prdata_r <= (hit && !pwrite) ? {16'h0000, rd_nxt} : 32'h0000_0000;
      end
   end

   // only unmapped or misaligned addresses are refused
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pslverr_r <= 1'b0;
      end else if (ce && setup_ph) begin
         pslverr_r <= ~hit;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

endmodule // rrsm_regmap

// [rrsm_regmap_asserts.sv]
// Purpose: port assertions for rrsm_regmap
// Assumes: ce goes low only while the bus is idle
// Notes:   bound from the testbench top
`timescale 1ns/1ps
module rrsm_regmap_asserts
   import rrsm_pkg::*;
#(
   parameter int AW = 8                  // apb address width
) (
   input wire logic              clock,   // system clock
   input wire logic              sys_rst, // sync reset
   input wire logic              ce,      // clock enable
   input wire logic [AW-1:0]     paddr,   // apb address
   input wire logic              psel,    // apb select
   input wire logic              penable, // apb access
   input wire logic              pwrite,  // apb direction
   input wire logic [31:0]       prdata,  // apb read data
   input wire logic              pready,  // apb ready
   input wire logic              pslverr, // apb error
   input wire logic [15:0]       meas_volt_tenths, // voltage in
   input wire logic [15:0]       meas_freq_tenths, // frequency in
   input wire logic signed [15:0] ref_variation,  // variation out
   input wire logic [3:0]        ref_mode, // source out
   input wire logic [15:0]       cfg_word  // config out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable && ce;
   endsequence
   sequence s_rd(logic [7:0] a);
      s_setup ##0 (!pwrite && paddr == a);
   endsequence
   property p_ready_after_setup;
      s_setup |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing");
   property p_ready_single;
      pready && ce |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single) else $error("ready too long");
   property p_volt_read;
      s_rd(8'h90) |=> prdata[15:0] == $past(meas_volt_tenths);
   endproperty
   a_volt_read: assert property (p_volt_read) else $error("voltage read wrong");
   property p_freq_read;
      s_rd(8'h94) |=> prdata[15:0] == $past(meas_freq_tenths);
   endproperty
   a_freq_read: assert property (p_freq_read) else $error("frequency read wrong");
   property p_mirror;
      pready && !pwrite && paddr == 8'h9C |-> {prdata[15], prdata[13:7], prdata[5:3],
         prdata[1:0]} == {cfg_word[15], cfg_word[13:7], cfg_word[5:3], cfg_word[1:0]};
   endproperty
   a_mirror: assert property (p_mirror) else $error("status not mirroring config");
   property p_mode_analog;
      $stable(cfg_word) && cfg_word[12] |-> ref_mode == (cfg_word[7] ? 4'b0010 : 4'b0001);
   endproperty
   a_mode_analog: assert property (p_mode_analog) else $error("analog mode wrong");
   property p_mode_stored;
      $stable(cfg_word) && !cfg_word[12] && !cfg_word[7] |-> ref_mode == 4'b0100
         && ref_variation == 16'sh0000;
   endproperty
   a_mode_stored: assert property (p_mode_stored) else $error("stored mode wrong");
   property p_mode_ram;
      $stable(cfg_word) && !cfg_word[12] && cfg_word[7] |-> ref_mode == 4'b1000;
   endproperty
   a_mode_ram: assert property (p_mode_ram) else $error("volatile mode wrong");
   property p_misalign;
      s_setup ##0 (paddr[1:0] != 2'b00) |=> pready && pslverr && prdata == 32'h0;
   endproperty
   a_misalign: assert property (p_misalign) else $error("misaligned not refused");
endmodule // rrsm_regmap_asserts

// [rrsm_host_model.sv]
// Purpose: apb host standing in for the supervisor
// Assumes: slave answers within 50 cycles
// Notes:   signals move only just after a rising edge
`timescale 1ns/1ps
module rrsm_host_model (
   input  wire logic        clock,    // system clock
   input  wire logic [31:0] prdata,   // read data
   input  wire logic        pready,   // ready
   input  wire logic        pslverr,  // error
   output logic             psel,     // select
   output logic             penable,  // access phase
   output logic             pwrite,   // direction
   output logic [7:0]       paddr,    // byte address
   output logic [31:0]      pwdata,   // write data
   output logic             timed_out // no answer in time
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hFF;
      pwdata = 32'h0;
      timed_out = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] v,
                       output logic [31:0] d, output logic e);
      int n;
      d = 32'h0;
      e = 1'b0;
      if (w && a == 8'hA0) return;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, v};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) timed_out <= 1'b1;
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~pwdata;
   endtask
endmodule // rrsm_host_model

// [regulator_remote_ref_status_map_tb.sv]
// Purpose: self-checking bench for rrsm_regmap
// Assumes: ce low only while the bus is idle
// Notes:   status inputs come from a table
`timescale 1ns/1ps
module regulator_remote_ref_status_map_tb;
   import rrsm_pkg::*;
   logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, tout;
   logic jumper, three_ph, lost, ce;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [15:0] ref_base, cfg_word;
   logic signed [15:0] ref_var;
   logic [3:0] ref_mode;
   logic [15:0] st [0:14];
   logic [7:0] sa [0:14] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'hA4,
                             8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hC8, 8'hCC, 8'hD0};
   logic [15:0] es [0:3] = '{16'h1F14, 16'h1F50, 16'h5F14, 16'h5F50};
   logic e;
   int mismatches, num_checks, i;
   rrsm_regmap dut (.clock(clock), .sys_rst(sys_rst), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .jumper_60hz_pin(jumper), .three_phase_pin(three_ph),
      .ext_link_lost_pin(lost), .volt_knob(st[0]), .gain_knob(st[1]), .freq_knob(st[2]),
      .field_current_knob(st[3]), .meas_volt_tenths(st[4]), .meas_freq_tenths(st[5]),
      .alarm_flags(st[6]), .ext_input_value(st[7]), .nominal_target(st[8]),
      .working_target(st[9]), .volt_sample(st[10]), .heat_estimate(st[11]),
      .swing_amplitude(st[12]), .polyphase_level(st[13]), .offset_estimate(st[14]),
      .ref_base(ref_base), .ref_variation(ref_var), .ref_mode(ref_mode), .cfg_word(cfg_word));
   rrsm_host_model host (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .timed_out(tout));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      host.xfer(1'b1, a, v, d, e);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      host.xfer(1'b0, a, 16'h0000, d, e);
      check(d[15:0], exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
   endtask
   always @(posedge clock) begin
      if (tout === 1'b1) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      jumper = 1'b0;
      three_ph = 1'b0;
      lost = 1'b0;
      for (i = 0; i < 15; i++) st[i] = 16'h1000 + 16'(i) * 16'h0111;
      settle(10);
      sys_rst <= 1'b0;
      for (i = 0; i < 15; i++) rchk(sa[i], st[i]);
      wr(8'h90, 16'hFFFF);
      rchk(8'h90, st[4]);
      host.xfer(1'b0, 8'h00, 16'h0000, d, e);
      check({15'h0, e}, 16'h0001);
      host.xfer(1'b0, 8'h91, 16'h0000, d, e);
      check({15'h0, e}, 16'h0001);
      check(d[15:0], 16'h0000);
      check(d[31:16], 16'h0000);
      $display("status map test done");
      rchk(8'h40, 16'h1F14);
      for (i = 0; i < 4; i++) begin
         three_ph <= i[0];
         jumper <= i[1];
         settle(5);
         rchk(8'h9C, es[i]);
      end
      rchk(8'hD0, 16'h0000);
      three_ph <= 1'b0;
      wr(8'h40, 16'h3F04);
      settle(3);
      rchk(8'h9C, 16'h3F04);
      $display("status word test done");
      wr(8'h40, 16'h0F14);
      wr(8'hC4, 16'h1234);
      settle(2);
      check({12'h000, ref_mode}, 16'h0004);
      check(ref_base, 16'h4000);
      wr(8'h44, 16'h2000);
      settle(2);
      check(ref_base, 16'h2000);
      wr(8'h40, 16'h0F94);
      settle(2);
      check({12'h000, ref_mode}, 16'h0008);
      check(ref_base, 16'h2000);
      wr(8'hC4, 16'h1234);
      settle(2);
      check(ref_base, 16'h1234);
      $display("digital reference test done");
      sys_rst <= 1'b1;
      settle(2);
      sys_rst <= 1'b0;
      check(ref_base, 16'h4000);
      check({12'h000, ref_mode}, 16'h0001);
      check(cfg_word, 16'h1F14);
      rchk(8'h40, 16'h1F14);
      rchk(8'h44, 16'h4000);
      $display("mid-run reset test done");
      wr(8'h48, 16'h0CCD);
      wr(8'h40, 16'h1F14);
      st[7] <= 16'h7FFF;
      settle(3);
      check(ref_var, 16'h0CCC);
      wr(8'h40, 16'h1F94);
      settle(3);
      check({12'h000, ref_mode}, 16'h0002);
      check(ref_var, 16'h0CCD);
      st[7] <= 16'h4000;
      lost <= 1'b1;
      settle(6);
      check(ref_var, 16'h0CCD);
      ce <= 1'b0;
      lost <= 1'b0;
      st[7] <= 16'h0000;
      settle(6);
      check(ref_var, 16'h0CCD);
      ce <= 1'b1;
      settle(6);
      check(ref_var, 16'hF333);
      $display("analog reference test done");
      summarize();
   end
endmodule // regulator_remote_ref_status_map_tb
bind rrsm_regmap rrsm_regmap_asserts #(.AW(AW)) u_chk (.clock(clock), .sys_rst(sys_rst),
   .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_volt_tenths(meas_volt_tenths),
   .meas_freq_tenths(meas_freq_tenths), .ref_variation(ref_variation),
   .ref_mode(ref_mode), .cfg_word(cfg_word));
